//--- hw/hra_pkg.sv
// shared constants, types and decode helpers of the hub address router
// assumes a single core clock domain and 36-bit physical addresses
package hra_pkg;

  // initiators, request kinds, routing targets and terminations
  typedef enum logic [1:0] {src_cpu = 2'h0, src_hub = 2'h1, src_gfx = 2'h2} hra_src_t;
  typedef enum logic [2:0] {
    kind_mem_rd  = 3'h0,
    kind_mem_wr  = 3'h1,
    kind_io_rd   = 3'h2,
    kind_io_wr   = 3'h3,
    kind_cfg     = 3'h4,
    kind_special = 3'h5
  } hra_kind_t;
  typedef enum logic [2:0] {
    tgt_none     = 3'h0,
    tgt_mem      = 3'h1,
    tgt_hub      = 3'h2,
    tgt_gfx      = 3'h3,
    tgt_internal = 3'h4
  } hra_tgt_t;
  typedef enum logic [2:0] {
    act_claim        = 3'h0,
    act_master_abort = 3'h1,
    act_drop         = 3'h2,
    act_silent       = 3'h3,
    act_remap_zero   = 3'h4,
    act_invalid_data = 3'h5
  } hra_act_t;
  typedef enum logic [1:0] {st_idle = 2'b01, st_resp = 2'b10} hra_state_t;

  // fixed address ranges
  localparam logic [35:0] FOUR_GB   = 36'h1_0000_0000;
  localparam logic [35:0] COMPAT_LO = 36'h0_000a_0000;
  localparam logic [35:0] COMPAT_HI = 36'h0_000b_ffff;
  localparam logic [35:0] HIGH_LO   = 36'h0_feda_0000;
  localparam logic [35:0] HIGH_HI   = 36'h0_fedb_ffff;
  localparam logic [35:0] LEGACY_LO = 36'h0_000c_0000;
  localparam logic [35:0] LEGACY_HI = 36'h0_000f_ffff;
  localparam logic [35:0] TOP_128K  = 36'h0_0002_0000;
  localparam logic [35:0] TOP_256K  = 36'h0_0004_0000;
  localparam logic [35:0] TOP_512K  = 36'h0_0008_0000;
  localparam logic [35:0] TOP_1M    = 36'h0_0010_0000;

  // i/o space, transfer limits and aperture encoding
  localparam logic [15:0] CFG_ADDR_PORT = 16'h0cf8;
  localparam logic [15:0] CFG_DATA_PORT = 16'h0cfc;
  localparam logic [15:0] IO_WRAP_FIRST = 16'hfffd;
  localparam logic [15:0] IO_TOP        = 16'hffff;
  localparam logic [12:0] PAGE_BYTES    = 13'h1000;
  localparam logic [12:0] PIPE_MAX_LEN  = 13'h0100;
  localparam logic [12:0] LEN_TWO       = 13'h0002;
  localparam logic [12:0] LEN_FOUR      = 13'h0004;
  localparam logic [2:0]  APERTURE_SIZE_SELECT_RESET  = 3'h6;
  localparam logic [2:0]  APERTURE_SIZE_SELECT_MAX    = 3'h6;
  localparam logic [9:0]  AP_BASE_RESET = 10'h000;

  // inclusive range test
  function automatic logic hra_in_range(logic [35:0] a, logic [35:0] lo, logic [35:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // programmable bits [31:22] of the aperture base for a size code (0 = 4 MB)
  function automatic logic [9:0] hra_ap_mask(logic [2:0] sel);
    return 10'h3ff << sel;
  endfunction

endpackage

//--- hw/hra_mgmt_decode.sv
// decode of the three management ram ranges and the high segment remap
// assumes config inputs are static while requests are presented
`timescale 1ns/10ps
`default_nettype none
module hra_mgmt_decode (
  input  wire logic [35:0] addr_i,
  input  wire logic [35:0] top_of_low_memory_i,
  input  wire logic        global_en_i,
  input  wire logic        open_i,
  input  wire logic        close_i,
  input  wire logic        smm_req_i,
  input  wire logic        high_en_i,
  input  wire logic        top_en_i,
  input  wire logic [1:0]  top_size_i,
  output logic             compat_hit_o,
  output logic             high_hit_o,
  output logic             top_hit_o,
  output logic             access_ok_o,
  output logic [35:0]      remap_addr_o
);
  import hra_pkg::*;

  logic [35:0] top_bytes;
  logic [35:0] top_base;

  // top segment ends at top of low memory, size 128 KB to 1 MB
  always_comb begin
    case (top_size_i)
      2'h0:    top_bytes = TOP_128K;
      2'h1:    top_bytes = TOP_256K;
      2'h2:    top_bytes = TOP_512K;
      default: top_bytes = TOP_1M;
    endcase
  end
  assign top_base = top_of_low_memory_i - top_bytes;

  // range hits, only while the regions are enabled
  assign compat_hit_o = global_en_i && hra_in_range(addr_i, COMPAT_LO, COMPAT_HI);
  assign high_hit_o   = global_en_i && high_en_i && hra_in_range(addr_i, HIGH_LO, HIGH_HI);
  assign top_hit_o    = global_en_i && top_en_i && (addr_i >= top_base)
                        && (addr_i < top_of_low_memory_i);

  // open and close set together is left undefined by software contract
  assign access_ok_o  = global_en_i && ((open_i && !close_i) || smm_req_i);

  // high segment folds onto the compatible range, others pass unchanged
  assign remap_addr_o = high_hit_o ? (COMPAT_LO | {19'h0, addr_i[16:0]}) : addr_i;

endmodule
`default_nettype wire

//--- hw/hra_aperture_regs.sv
// aperture base and size select registers with natural alignment
// assumes write strobes come from configuration logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module hra_aperture_regs (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        base_wr_i,
  input  wire logic [31:0] base_wdata_i,
  input  wire logic        size_wr_i,
  input  wire logic [2:0]  size_wdata_i,
  output logic [31:0]      aperture_base_o,
  output logic [2:0]       aperture_size_select_o
);
  import hra_pkg::*;

  logic [9:0] base;
  logic [9:0] next_base;
  logic [2:0] size_sel;
  logic [2:0] next_size_sel;

  // size codes above 256 MB are refused; base bits below the size stay zero
  always_comb begin
    next_size_sel = size_sel;
    if (size_wr_i && (size_wdata_i <= APERTURE_SIZE_SELECT_MAX)) begin
      next_size_sel = size_wdata_i;
    end
    next_base = (base_wr_i ? base_wdata_i[31:22] : base) & hra_ap_mask(next_size_sel);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      size_sel <= APERTURE_SIZE_SELECT_RESET;
      base     <= AP_BASE_RESET;
    end else begin
      size_sel <= next_size_sel;
      base     <= next_base;
    end
  end

  assign aperture_base_o        = {base, 22'h0};
  assign aperture_size_select_o = size_sel;

  chk_ap_aligned: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (base & ~hra_ap_mask(size_sel)) == 10'h000)
    else $error("aperture base not aligned to its size");
  chk_ap_size_kept: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (size_wr_i && (size_wdata_i > APERTURE_SIZE_SELECT_MAX)) |=> $stable(size_sel))
    else $error("illegal aperture size accepted");

endmodule
`default_nettype wire

//--- hw/hra_router.sv
// hub address decode router: steers each request to memory, hub, graphics port or internal target, or terminates it
// assumes one request per cycle from logic on ref_clk_i; answer follows one cycle later
// How it works
// - addresses from top of low memory to 4 GB unclaimed go to hub
// - graphics port claims addresses inside either memory window, bounds inclusive
// - aperture size selects 4 MB to 256 MB, resets to 256 MB
// - aperture base bits below the size read zero, writes ignored
// - aperture hits go to memory through the translation table
// - compatible management range reaches memory at identical addresses
// - high management segment remaps onto A0000h through BFFFFh
// - top segment 128 KB to 1 MB below top memory, not remapped
// - hub and graphics masters never reach management memory
// - processor i/o passes untranslated except the data port and 4-byte address port accesses
// - address bit 16 driven for wrapping 4-byte and 2-byte i/o accesses
// - hub and graphics i/o or config: abort, drop or silence
// - hub reads above 4 GB master abort, writes above 4 GB dropped
// - hub accepts memory, window writes, aperture, enabled vga writes
// - graphics frame cycles claimed only for memory or aperture
// - graphics frame legacy reads claimed only when the region is readable
// - graphics i/o, config and special cycles get no response
// - pipelined misses: reads outside memory remap to zero, reads starting in memory return invalid data, both flag; writes drop
// - graphics cycles to memory are never snooped
// - graphics frame transfers disconnect at each 4 KB boundary
// - pipelined non-aperture requests over 256 bytes or crossing out get flagged
`timescale 1ns/10ps
`default_nettype none
module hra_router (
  input  wire logic              ref_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              req_valid_i,
  input  var  hra_pkg::hra_src_t  req_src_i,
  input  var  hra_pkg::hra_kind_t req_kind_i,
  input  wire logic              req_pipe_i,
  input  wire logic              req_posted_i,
  input  wire logic              req_smm_i,
  input  wire logic [35:0]       req_addr_i,
  input  wire logic [12:0]       req_len_i,
  input  wire logic [35:0]       top_of_low_memory_i,
  input  wire logic [35:0]       gfx_mem_window_base_i,
  input  wire logic [35:0]       gfx_mem_window_limit_i,
  input  wire logic [35:0]       gfx_prefetch_window_base_i,
  input  wire logic [35:0]       gfx_prefetch_window_limit_i,
  input  wire logic [15:0]       gfx_io_base_i,
  input  wire logic [15:0]       gfx_io_limit_i,
  input  wire logic              vga_to_gfx_en_i,
  input  wire logic [12:0]       legacy_readable_i,
  input  wire logic [12:0]       legacy_writable_i,
  input  wire logic              mgmt_global_en_i,
  input  wire logic              mgmt_open_i,
  input  wire logic              mgmt_close_i,
  input  wire logic              high_mgmt_segment_en_i,
  input  wire logic              top_mgmt_segment_en_i,
  input  wire logic [1:0]        top_mgmt_segment_size_i,
  input  wire logic              aperture_wr_i,
  input  wire logic [31:0]       aperture_base_wdata_i,
  input  wire logic              aperture_size_wr_i,
  input  wire logic [2:0]        aperture_size_wdata_i,
  input  wire logic              illegal_aperture_access_clear_i,
  output logic [31:0]            aperture_base_o,
  output logic [2:0]             aperture_size_select_o,
  output logic                   rsp_valid_o,
  output hra_pkg::hra_tgt_t       rsp_target_o,
  output hra_pkg::hra_act_t       rsp_action_o,
  output logic [35:0]            rsp_addr_o,
  output logic                   rsp_translate_o,
  output logic                   rsp_snoop_o,
  output logic                   io_wrap_addr_bit16_o,
  output logic                   rsp_disconnect_o,
  output logic [12:0]            rsp_xfer_len_o,
  output logic                   illegal_aperture_access_flag_o
);
  import hra_pkg::*;

  logic        compat_hit, high_hit, top_hit, mgmt_ok, mgmt_any;
  logic [35:0] mgmt_addr, last_addr;
  logic        ap_hit, win_hit, is_mem, is_wr, legacy_hit, legacy_ok, in_sysmem;
  logic [12:0] page_room;
  logic [3:0]  legacy_seg;
  hra_state_t  state, next_state;
  hra_tgt_t    next_target;
  hra_act_t    next_action;
  logic [35:0] next_addr;
  logic [12:0] next_xlen;
  logic        next_translate, next_snoop, next_wrap, next_disc, next_flag, set_flag;

  hra_aperture_regs u_ap (
    .ref_clk_i              (ref_clk_i),
    .resetn_i               (resetn_i),
    .base_wr_i              (aperture_wr_i),
    .base_wdata_i           (aperture_base_wdata_i),
    .size_wr_i              (aperture_size_wr_i),
    .size_wdata_i           (aperture_size_wdata_i),
    .aperture_base_o        (aperture_base_o),
    .aperture_size_select_o (aperture_size_select_o)
  );

  hra_mgmt_decode u_mgmt (
    .addr_i              (req_addr_i),
    .top_of_low_memory_i (top_of_low_memory_i),
    .global_en_i         (mgmt_global_en_i),
    .open_i              (mgmt_open_i),
    .close_i             (mgmt_close_i),
    .smm_req_i           (req_smm_i),
    .high_en_i           (high_mgmt_segment_en_i),
    .top_en_i            (top_mgmt_segment_en_i),
    .top_size_i          (top_mgmt_segment_size_i),
    .compat_hit_o        (compat_hit),
    .high_hit_o          (high_hit),
    .top_hit_o           (top_hit),
    .access_ok_o         (mgmt_ok),
    .remap_addr_o        (mgmt_addr)
  );

  // address classification shared by all initiators
  assign mgmt_any   = compat_hit || high_hit || top_hit;
  assign last_addr  = req_addr_i + {23'h0, req_len_i} - 36'h1;
  assign is_mem     = (req_kind_i == kind_mem_rd) || (req_kind_i == kind_mem_wr);
  assign is_wr      = (req_kind_i == kind_mem_wr);
  assign ap_hit     = (req_addr_i[35:32] == 4'h0) && ((req_addr_i[31:22]
                      & hra_ap_mask(aperture_size_select_o)) == aperture_base_o[31:22]);
  assign win_hit    = hra_in_range(req_addr_i, gfx_mem_window_base_i, gfx_mem_window_limit_i)
                      || hra_in_range(req_addr_i, gfx_prefetch_window_base_i,
                                      gfx_prefetch_window_limit_i);
  assign in_sysmem  = (req_addr_i < top_of_low_memory_i) && !mgmt_any;
  assign legacy_hit = hra_in_range(req_addr_i, LEGACY_LO, LEGACY_HI);
  assign legacy_seg = (req_addr_i[19:16] == 4'hf) ? 4'hc : req_addr_i[17:14];
  assign legacy_ok  = is_wr ? legacy_writable_i[legacy_seg] : legacy_readable_i[legacy_seg];
  assign page_room  = PAGE_BYTES - {1'b0, req_addr_i[11:0]};

  // routing decision for the request presented this cycle
  always_comb begin
    next_target    = tgt_none;
    next_action    = act_silent;
    next_addr      = req_addr_i;
    next_xlen      = req_len_i;
    next_translate = 1'b0;
    next_snoop     = 1'b0;
    next_wrap      = 1'b0;
    next_disc      = 1'b0;
    set_flag       = 1'b0;
    case (req_src_i)
      src_cpu: begin
        next_action = act_claim;
        if (is_mem) begin
          if (mgmt_any && mgmt_ok) begin
            next_target = tgt_mem;
            next_addr   = mgmt_addr;
          end else if (ap_hit) begin
            next_target    = tgt_mem;
            next_translate = 1'b1;
          end else if (win_hit) begin
            next_target = tgt_gfx;
          end else if (in_sysmem) begin
            next_target = tgt_mem;
          end else begin
            next_target = tgt_hub;
          end
        end else if (req_kind_i == kind_cfg) begin
          next_target = tgt_internal;
        end else if (req_kind_i == kind_special) begin
          next_target = tgt_hub;
        end else begin
          // only 4-byte address port and all data port accesses stay inside, the rest passes untranslated
          if ((req_addr_i[16:2] == {1'b0, CFG_ADDR_PORT[15:2]} && req_len_i == LEN_FOUR)
              || req_addr_i[16:2] == {1'b0, CFG_DATA_PORT[15:2]}) begin
            next_target = tgt_internal;
          end else if (req_addr_i[15:0] >= gfx_io_base_i && req_addr_i[15:0] <= gfx_io_limit_i) begin
            next_target = tgt_gfx;
          end else begin
            next_target = tgt_hub;
          end
          next_wrap = ((req_len_i == LEN_FOUR) && (req_addr_i[15:0] >= IO_WRAP_FIRST))
                      || ((req_len_i == LEN_TWO) && (req_addr_i[15:0] == IO_TOP));
        end
      end
      src_hub: begin
        next_action = is_wr ? act_drop : act_master_abort;
        next_snoop  = 1'b1;
        if (!is_mem) begin
          next_action = req_posted_i ? act_drop : act_master_abort;
        end else if (req_addr_i >= FOUR_GB) begin
          next_action = is_wr ? act_drop : act_master_abort;
        end else if (mgmt_any) begin
          next_action = is_wr ? act_drop : act_master_abort;
        end else if (ap_hit) begin
          next_target    = tgt_mem;
          next_action    = act_claim;
          next_translate = 1'b1;
        end else if (is_wr && (win_hit || (vga_to_gfx_en_i
                     && hra_in_range(req_addr_i, COMPAT_LO, COMPAT_HI)))) begin
          next_target = tgt_gfx;
          next_action = act_claim;
        end else if (in_sysmem) begin
          next_target = tgt_mem;
          next_action = act_claim;
        end
      end
      src_gfx: begin
        if (!is_mem) begin
          next_action = act_silent;
        end else if (req_pipe_i) begin
          if (ap_hit) begin
            next_target    = tgt_mem;
            next_action    = act_claim;
            next_translate = 1'b1;
          end else if (in_sysmem && last_addr < top_of_low_memory_i
                       && req_len_i <= PIPE_MAX_LEN) begin
            next_target = tgt_mem;
            next_action = act_claim;
          end else if (!is_wr) begin
            next_target = tgt_mem;
            next_action = in_sysmem ? act_invalid_data : act_remap_zero;
            next_addr   = in_sysmem ? req_addr_i : 36'h0;
            set_flag    = 1'b1;
          end else begin
            next_action = act_drop;
            set_flag    = in_sysmem || (req_len_i > PIPE_MAX_LEN);
          end
        end else begin
          if (mgmt_any) begin
            next_action = act_silent;
          end else if (legacy_hit ? legacy_ok : (ap_hit || in_sysmem)) begin
            next_target    = tgt_mem;
            next_action    = act_claim;
            next_translate = ap_hit && !legacy_hit;
            if (req_len_i > page_room) begin
              next_disc = 1'b1;
              next_xlen = page_room;
            end
          end
        end
      end
      default: begin
        next_action = act_silent;
      end
    endcase
  end

  // answer sequencing and the sticky error flag, a new hit wins over a clear
  always_comb begin
    next_state = req_valid_i ? st_resp : st_idle;
    next_flag  = (req_valid_i && set_flag)
                 || (illegal_aperture_access_flag_o && !illegal_aperture_access_clear_i);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state                          <= st_idle;
      rsp_target_o                   <= tgt_none;
      rsp_action_o                   <= act_silent;
      rsp_addr_o                     <= 36'h0;
      rsp_xfer_len_o                 <= 13'h0000;
      rsp_translate_o                <= 1'b0;
      rsp_snoop_o                    <= 1'b0;
      io_wrap_addr_bit16_o           <= 1'b0;
      rsp_disconnect_o               <= 1'b0;
      illegal_aperture_access_flag_o <= 1'b0;
    end else begin
      state                          <= next_state;
      rsp_target_o                   <= req_valid_i ? next_target : tgt_none;
      rsp_action_o                   <= req_valid_i ? next_action : act_silent;
      rsp_addr_o                     <= next_addr;
      rsp_xfer_len_o                 <= next_xlen;
      rsp_translate_o                <= req_valid_i && next_translate;
      rsp_snoop_o                    <= req_valid_i && next_snoop;
      io_wrap_addr_bit16_o           <= req_valid_i && next_wrap;
      rsp_disconnect_o               <= req_valid_i && next_disc;
      illegal_aperture_access_flag_o <= next_flag;
    end
  end

  assign rsp_valid_o = (state == st_resp);

  // checks on the routing outcome
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_pipe_miss_rd;
    req_valid_i && req_src_i == src_gfx && req_pipe_i && req_kind_i == kind_mem_rd
    && !ap_hit && req_addr_i >= top_of_low_memory_i;
  endsequence
  sequence s_zero_read;
    rsp_addr_o == 36'h0 && rsp_action_o == act_remap_zero && illegal_aperture_access_flag_o;
  endsequence

  chk_sub_to_hub: assert property (req_valid_i && req_src_i == src_cpu && is_mem
    && req_addr_i >= top_of_low_memory_i && req_addr_i < FOUR_GB && !ap_hit && !win_hit
    && !mgmt_any |=> rsp_target_o == tgt_hub) else $error("unclaimed access not sent to hub");
  chk_window_claim: assert property (req_valid_i && req_src_i == src_cpu && is_mem
    && win_hit && !ap_hit && !mgmt_any |=> rsp_target_o == tgt_gfx)
    else $error("window access not sent to graphics port");
  chk_high_remap: assert property (req_valid_i && req_src_i == src_cpu && is_mem
    && high_hit && mgmt_ok |=> rsp_target_o == tgt_mem
    && rsp_addr_o == (COMPAT_LO | {19'h0, $past(req_addr_i[16:0])}))
    else $error("high segment not remapped");
  chk_no_mgmt_foreign: assert property (req_valid_i && req_src_i != src_cpu && mgmt_any
    |=> !(rsp_target_o == tgt_mem && rsp_action_o == act_claim))
    else $error("foreign master reached management memory");
  chk_hub_above_4g: assert property (req_valid_i && req_src_i == src_hub
    && req_kind_i == kind_mem_rd && req_addr_i >= FOUR_GB |=> rsp_action_o == act_master_abort)
    else $error("hub read above 4 GB not aborted");
  chk_gfx_io_silent: assert property (req_valid_i && req_src_i == src_gfx && !is_mem
    |=> rsp_action_o == act_silent && rsp_target_o == tgt_none)
    else $error("graphics i/o cycle answered");
  chk_pipe_zero_read: assert property (s_pipe_miss_rd |=> s_zero_read)
    else $error("pipelined miss not remapped to zero");
  chk_gfx_no_snoop: assert property (req_valid_i && req_src_i == src_gfx
    |=> !rsp_snoop_o) else $error("graphics cycle snooped");
  chk_frame_4k: assert property (req_valid_i && req_src_i == src_gfx && !req_pipe_i
    && next_target == tgt_mem && req_len_i > page_room
    |=> rsp_disconnect_o && rsp_xfer_len_o == $past(page_room))
    else $error("frame cycle not disconnected at page boundary");
  chk_flag_sticky: assert property (illegal_aperture_access_flag_o
    && !illegal_aperture_access_clear_i |=> illegal_aperture_access_flag_o [*1])
    else $error("error flag lost");
  chk_io_wrap: assert property (req_valid_i && req_src_i == src_cpu
    && req_kind_i == kind_io_rd && req_len_i == LEN_FOUR && req_addr_i[15:0] == IO_TOP
    |=> io_wrap_addr_bit16_o) else $error("wrap bit 16 missing");

endmodule
`default_nettype wire

//--- test/hra_initiator.sv
// request source model for the processor, hub and graphics initiators
// assumes the router takes a request on the rising edge of ref_clk_i
`timescale 1ns/10ps
`default_nettype none
module hra_initiator (
  input  wire logic              ref_clk_i,
  output logic                   req_valid_o,
  output var hra_pkg::hra_src_t  req_src_o,
  output var hra_pkg::hra_kind_t req_kind_o,
  output logic                   req_pipe_o,
  output logic                   req_smm_o,
  output logic [35:0]            req_addr_o,
  output logic [12:0]            req_len_o
);
  import hra_pkg::*;
  // idle bus until the first request
  initial begin
    req_valid_o = 1'b0;
    req_src_o = src_cpu;
    req_kind_o = kind_mem_rd;
    req_pipe_o = 1'b0;
    req_smm_o = 1'b0;
    req_addr_o = 36'h0;
    req_len_o = 13'h0004; // pipelined requests stay far under 256 bytes
  end
  // one request held for one edge, answer settled on return
  task automatic send(input hra_src_t s, input hra_kind_t k, input logic p, input logic m,
                      input logic [35:0] a);
    @(posedge ref_clk_i);
    req_src_o <= s;
    req_kind_o <= k;
    req_pipe_o <= p;
    req_smm_o <= m;
    req_addr_o <= a;
    req_valid_o <= 1'b1;
    @(posedge ref_clk_i);
    req_valid_o <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench of the hub address router
// assumes the initiator model drives requests and this bench drives configuration
`timescale 1ns/10ps
`default_nettype none
module tb;
  import hra_pkg::*;
  logic ref_clk_i, resetn_i, req_valid_i, req_pipe_i, req_posted_i, req_smm_i;
  logic [35:0] req_addr_i, top_of_low_memory_i, gfx_mem_window_base_i, gfx_mem_window_limit_i;
  logic [35:0] gfx_prefetch_window_base_i, gfx_prefetch_window_limit_i, rsp_addr_o;
  logic [12:0] req_len_i, legacy_readable_i, legacy_writable_i, rsp_xfer_len_o;
  logic [15:0] gfx_io_base_i, gfx_io_limit_i;
  logic [31:0] aperture_base_wdata_i, aperture_base_o;
  logic [2:0]  aperture_size_wdata_i, aperture_size_select_o;
  logic [1:0]  top_mgmt_segment_size_i;
  logic vga_to_gfx_en_i, mgmt_global_en_i, mgmt_open_i, mgmt_close_i, high_mgmt_segment_en_i;
  logic top_mgmt_segment_en_i, aperture_wr_i, aperture_size_wr_i, illegal_aperture_access_clear_i;
  logic rsp_valid_o, rsp_translate_o, rsp_snoop_o, io_wrap_addr_bit16_o, rsp_disconnect_o;
  logic illegal_aperture_access_flag_o;
  hra_src_t  req_src_i;
  hra_kind_t req_kind_i;
  hra_tgt_t  rsp_target_o;
  hra_act_t  rsp_action_o;
  int err_total, total_checks, cyc;
  hra_router dut_u (.*);
  hra_initiator ini_u (.ref_clk_i, .req_valid_o(req_valid_i), .req_src_o(req_src_i),
    .req_kind_o(req_kind_i), .req_pipe_o(req_pipe_i), .req_smm_o(req_smm_i),
    .req_addr_o(req_addr_i), .req_len_o(req_len_i));
  // clock generation
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // compare and count
  task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // shrink the aperture to 4 mb, then write a base with low bits set
  task automatic ap_align;
    @(posedge ref_clk_i);
    aperture_size_wr_i <= 1'b1;
    aperture_size_wdata_i <= 3'h0;
    @(posedge ref_clk_i);
    aperture_size_wr_i <= 1'b0;
    aperture_wr_i <= 1'b1;
    aperture_base_wdata_i <= 32'hd0ff_ffff;
    @(posedge ref_clk_i);
    aperture_wr_i <= 1'b0;
    #1;
    chk("ap_size", aperture_size_select_o, 36'h0);
    chk("ap_base", aperture_base_o, 36'hd0c0_0000);
    // widen back to 256 mb, then try the refused code 7
    @(posedge ref_clk_i);
    aperture_size_wr_i <= 1'b1;
    aperture_size_wdata_i <= 3'h6;
    @(posedge ref_clk_i);
    aperture_size_wdata_i <= 3'h7;
    @(posedge ref_clk_i);
    aperture_size_wr_i <= 1'b0;
    #1;
    chk("ap_size_big", aperture_size_select_o, 36'h6);
    chk("ap_base_masked", aperture_base_o, 36'hd000_0000);
  endtask
  // processor decode: subtractive, windows, management ranges, aperture, i/o wrap
  task automatic cpu_routes;
    ini_u.send(src_cpu, kind_mem_rd, 1'b0, 1'b0, 36'h0_8000_0000);
    chk("sub_tgt", rsp_target_o, tgt_hub);
    chk("rsp_valid", rsp_valid_o, 36'h1);
    ini_u.send(src_cpu, kind_mem_rd, 1'b0, 1'b0, 36'h0_e0ff_ffff);
    chk("win_tgt", rsp_target_o, tgt_gfx);
    ini_u.send(src_cpu, kind_mem_rd, 1'b0, 1'b1, 36'h0_feda_0010);
    chk("high_addr", rsp_addr_o, 36'h0_000a_0010);
    ini_u.send(src_cpu, kind_mem_rd, 1'b0, 1'b1, 36'h0_000a_0010);
    chk("compat_addr", rsp_addr_o, 36'h0_000a_0010);
    chk("compat_tgt", rsp_target_o, tgt_mem);
    ini_u.send(src_cpu, kind_mem_rd, 1'b0, 1'b0, 36'h0_d0c0_0000);
    chk("ap_xlate", rsp_translate_o, 36'h1);
    ini_u.send(src_cpu, kind_io_rd, 1'b0, 1'b0, 36'h0_0000_fffe);
    chk("io_tgt", rsp_target_o, tgt_hub);
    chk("io_wrap", io_wrap_addr_bit16_o, 36'h1);
  endtask
  // hub and graphics port masters: aborts, silence, misses and page splits
  task automatic foreign_routes;
    ini_u.send(src_hub, kind_mem_rd, 1'b0, 1'b0, 36'h1_0000_0000);
    chk("hub_act", rsp_action_o, act_master_abort);
    ini_u.send(src_hub, kind_mem_rd, 1'b0, 1'b0, 36'h0_000a_0000);
    chk("hub_mgmt", rsp_action_o, act_master_abort);
    ini_u.send(src_gfx, kind_io_rd, 1'b0, 1'b0, 36'h0_0000_03b4);
    chk("gfx_io", rsp_action_o, act_silent);
    ini_u.send(src_gfx, kind_mem_rd, 1'b1, 1'b0, 36'h0_f000_0000);
    chk("pipe_act", rsp_action_o, act_remap_zero);
    chk("pipe_addr", rsp_addr_o, 36'h0);
    chk("pipe_flag", illegal_aperture_access_flag_o, 36'h1);
    ini_u.send(src_gfx, kind_mem_rd, 1'b0, 1'b0, 36'h0_1000_0ffe);
    chk("frame_disc", rsp_disconnect_o, 36'h1);
    chk("frame_len", rsp_xfer_len_o, 36'h2);
    chk("frame_snoop", rsp_snoop_o, 36'h0);
  endtask
  // hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 1000) begin
      err_total++;
      tally_and_finish;
    end
  end
  // configuration, reset and scenarios
  initial begin
    {resetn_i, req_posted_i, aperture_wr_i, aperture_size_wr_i} = 4'h0;
    {vga_to_gfx_en_i, mgmt_open_i, mgmt_close_i, illegal_aperture_access_clear_i} = 4'h0;
    {mgmt_global_en_i, high_mgmt_segment_en_i, top_mgmt_segment_en_i} = 3'h6;
    {aperture_base_wdata_i, aperture_size_wdata_i, top_mgmt_segment_size_i} = '0;
    {legacy_readable_i, legacy_writable_i} = '0;
    {gfx_io_base_i, gfx_io_limit_i} = {16'h1000, 16'h1fff};
    top_of_low_memory_i = 36'h0_4000_0000;
    {gfx_mem_window_base_i, gfx_mem_window_limit_i} = {36'h0_e000_0000, 36'h0_e0ff_ffff};
    {gfx_prefetch_window_base_i, gfx_prefetch_window_limit_i} = {36'h0_e100_0000, 36'h0_e1ff_ffff};
    repeat (16) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    #1;
    chk("size_rst", aperture_size_select_o, 36'h6);
    ap_align;
    cpu_routes;
    foreign_routes;
    tally_and_finish;
  end
endmodule
`default_nettype wire
